// ===== logic/ccss_pkg.sv
// Constants, strap codes and status carrier for the CPU clock source select
package ccss_pkg;

    localparam int STRAP_W = 3;
    localparam int CFG_W = 16;
    localparam int WD_DISABLE_BIT = 4;
    localparam int PER_W = 16;
    localparam int ACC_W = 17;
    localparam int K_W = 4;
    localparam int WD_W = 5;

    localparam logic [STRAP_W-1:0] STRAP_X4 = 3'h7;
    localparam logic [STRAP_W-1:0] STRAP_X3 = 3'h6;
    localparam logic [STRAP_W-1:0] STRAP_X2 = 3'h5;
    localparam logic [STRAP_W-1:0] STRAP_X5 = 3'h4;
    localparam logic [STRAP_W-1:0] STRAP_DIRECT = 3'h3;
    localparam logic [STRAP_W-1:0] STRAP_X1P5 = 3'h2;
    localparam logic [STRAP_W-1:0] STRAP_DIV2 = 3'h1;
    localparam logic [STRAP_W-1:0] STRAP_X2P5 = 3'h0;
    localparam logic [STRAP_W-1:0] STRAP_DEFAULT = STRAP_X4;

    // CPU half-cycles per input period, i.e. twice the factor
    localparam logic [K_W-1:0] HALVES_X4 = 4'h8;
    localparam logic [K_W-1:0] HALVES_X3 = 4'h6;
    localparam logic [K_W-1:0] HALVES_X2 = 4'h4;
    localparam logic [K_W-1:0] HALVES_X5 = 4'ha;
    localparam logic [K_W-1:0] HALVES_X1P5 = 4'h3;
    localparam logic [K_W-1:0] HALVES_X2P5 = 4'h5;
    localparam logic [K_W-1:0] HALVES_X1 = 4'h2;

    localparam logic [WD_W-1:0] WD_OVERFLOW = 5'h10;
    localparam logic [CFG_W-1:0] CFG_RESET = 16'h0000;

    // Free-running PLL half period; value is a plain model figure
    localparam int CLOCK_PERIOD_NS = 8;
    localparam int FREE_RUN_HALF_NS = 24;
    localparam int FREE_RUN_HALF_CYC =
        (FREE_RUN_HALF_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
    localparam logic [7:0] FREE_RUN_LAST = 8'(FREE_RUN_HALF_CYC - 1);

    typedef struct packed {
        logic [STRAP_W-1:0] mode;
        logic pll_on;
        logic watchdog_on;
        logic failover;
    } ccss_status_t;

endpackage

// ===== logic/ccss_sync.sv
// Two flip-flop synchroniser for pin inputs
`timescale 1ns/100ps
`default_nettype none
module ccss_sync #(
    parameter int W = 1
) (
    input wire logic clock,
    input wire logic srst,
    input wire logic [W-1:0] async_in,
    output logic [W-1:0] sync_out
);

    logic [W-1:0] meta_q;

    // First stage feeds only the second stage
    always_ff @(posedge clock) begin
        if (srst) begin
            meta_q <= '0;
            sync_out <= '0;
        end else begin
            meta_q <= async_in;
            sync_out <= meta_q;
        end
    end

endmodule
`default_nettype wire

// ===== logic/ccss_top.sv
// CPU clock source select: strap decode, multiplier, bypass, watchdog
`timescale 1ns/100ps
`default_nettype none
module ccss_top
    import ccss_pkg::*;
(
    input wire logic clock,
    input wire logic srst,
    input wire logic clock_input_pin,
    input wire logic [STRAP_W-1:0] clock_strap_pins,
    input wire logic system_config_wr,
    input wire logic [CFG_W-1:0] system_config_data,
    input wire logic clock_fail_irq_clear,
    output logic cpu_clock,
    output logic cpu_half_cycle,
    output logic clock_fail_irq,
    output logic pll_enable,
    output ccss_status_t status
);

    // ****************************************************************
    // Input synchronisation
    // ****************************************************************
    logic xin_s;
    logic [STRAP_W-1:0] strap_s;
    logic xin_prev_q;
    logic srst_prev_q;

    ccss_sync #(.W(1)) u_sync_xin (
        .clock(clock),
        .srst(srst),
        .async_in(clock_input_pin),
        .sync_out(xin_s)
    );

    ccss_sync #(.W(STRAP_W)) u_sync_strap (
        .clock(clock),
        .srst(1'b0),
        .async_in(clock_strap_pins),
        .sync_out(strap_s)
    );

    wire xin_rise = xin_s & ~xin_prev_q;
    wire xin_trans = xin_s ^ xin_prev_q;
    wire release_w = srst_prev_q & ~srst;

    // ****************************************************************
    // Strap latch and configuration
    // ****************************************************************
    logic [STRAP_W-1:0] mode_q;
    logic [CFG_W-1:0] cfg_q;

    always_ff @(posedge clock) begin
        srst_prev_q <= srst;
        xin_prev_q <= srst ? 1'b0 : xin_s;
    end

    // Pins only matter at the release; later toggling is ignored
    always_ff @(posedge clock) begin
        if (srst) begin
            mode_q <= STRAP_DEFAULT;
        end else if (release_w) begin
            mode_q <= strap_s;
        end
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            cfg_q <= CFG_RESET;
        end else if (system_config_wr) begin
            cfg_q <= system_config_data;
        end
    end

    wire wd_disable = cfg_q[WD_DISABLE_BIT];
    wire mode_direct = (mode_q == STRAP_DIRECT);
    wire mode_div2 = (mode_q == STRAP_DIV2);
    wire mode_bypass = mode_direct | mode_div2;
    wire wd_enabled = mode_bypass & ~wd_disable;
    wire pll_on = ~mode_bypass | ~wd_disable;

    logic [K_W-1:0] halves_w;
    always_comb begin
        case (mode_q)
            STRAP_X4: halves_w = HALVES_X4;
            STRAP_X3: halves_w = HALVES_X3;
            STRAP_X2: halves_w = HALVES_X2;
            STRAP_X5: halves_w = HALVES_X5;
            STRAP_X1P5: halves_w = HALVES_X1P5;
            STRAP_X2P5: halves_w = HALVES_X2P5;
            default: halves_w = HALVES_X1;
        endcase
    end

    // ****************************************************************
    // Free-running PLL oscillator
    // ****************************************************************
    logic [7:0] fr_cnt_q;
    logic fr_lvl_q;
    wire fr_tick = pll_on & (fr_cnt_q == FREE_RUN_LAST);
    wire fr_rise = fr_tick & ~fr_lvl_q;

    always_ff @(posedge clock) begin
        if (srst | ~pll_on) begin
            fr_cnt_q <= '0;
            fr_lvl_q <= 1'b0;
        end else if (fr_tick) begin
            fr_cnt_q <= '0;
            fr_lvl_q <= ~fr_lvl_q;
        end else begin
            fr_cnt_q <= fr_cnt_q + 8'h01;
        end
    end

    // ****************************************************************
    // Oscillator watchdog
    // ****************************************************************
    logic [WD_W-1:0] wd_cnt_q;
    logic failover_q;
    wire wd_ovf = (wd_cnt_q == WD_OVERFLOW);
    wire fail_set = wd_enabled & wd_ovf & ~failover_q;

    always_ff @(posedge clock) begin
        if (srst | ~wd_enabled | xin_trans) begin
            wd_cnt_q <= '0;
        end else if (fr_rise & ~wd_ovf) begin
            wd_cnt_q <= wd_cnt_q + 5'h01;
        end
    end

    // Sticky: a returning input clock must not pull the CPU back
    always_ff @(posedge clock) begin
        if (srst) begin
            failover_q <= 1'b0;
        end else if (fail_set) begin
            failover_q <= 1'b1;
        end
    end

    // Set wins over a clear in the same cycle
    always_ff @(posedge clock) begin
        if (srst) begin
            clock_fail_irq <= 1'b0;
        end else if (fail_set) begin
            clock_fail_irq <= 1'b1;
        end else if (clock_fail_irq_clear) begin
            clock_fail_irq <= 1'b0;
        end
    end

    // ****************************************************************
    // Multiplier: fractional edge placement over the input period
    // ****************************************************************
    logic [PER_W-1:0] per_cnt_q;
    logic [PER_W-1:0] per_q;
    logic [ACC_W-1:0] acc_q;
    logic mult_lvl_q;
    wire [ACC_W-1:0] acc_sum = acc_q + {{(ACC_W-K_W){1'b0}}, halves_w};
    wire [ACC_W-1:0] per_ext = {1'b0, per_q};
    wire mult_tick = ~xin_rise & (per_q != '0) & (acc_sum >= per_ext);

    always_ff @(posedge clock) begin
        if (srst) begin
            per_cnt_q <= '0;
            per_q <= '0;
        end else if (xin_rise) begin
            per_cnt_q <= '0;
            per_q <= per_cnt_q + 16'h0001;
        end else if (per_cnt_q != 16'hffff) begin
            per_cnt_q <= per_cnt_q + 16'h0001;
        end
    end

    // Each input rise is itself an edge; forcing a level there would lose
    // one edge per period for the odd factors 1.5 and 2.5
    always_ff @(posedge clock) begin
        if (srst) begin
            acc_q <= '0;
            mult_lvl_q <= 1'b0;
        end else if (xin_rise) begin
            acc_q <= '0;
            mult_lvl_q <= ~mult_lvl_q;
        end else if (mult_tick) begin
            acc_q <= acc_sum - per_ext;
            mult_lvl_q <= ~mult_lvl_q;
        end else begin
            acc_q <= acc_sum;
        end
    end

    // ****************************************************************
    // Prescaler and output selection
    // ****************************************************************
    logic presc_q;
    always_ff @(posedge clock) begin
        if (srst) begin
            presc_q <= 1'b0;
        end else if (xin_rise) begin
            presc_q <= ~presc_q;
        end
    end

    logic cpu_next;
    always_comb begin
        if (failover_q) begin
            cpu_next = fr_lvl_q;
        end else if (mode_direct) begin
            cpu_next = xin_s;
        end else if (mode_div2) begin
            cpu_next = presc_q;
        end else begin
            cpu_next = mult_lvl_q;
        end
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            cpu_clock <= 1'b0;
            cpu_half_cycle <= 1'b0;
        end else begin
            cpu_clock <= cpu_next;
            cpu_half_cycle <= cpu_next ^ cpu_clock;
        end
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            pll_enable <= 1'b1;
            status <= '0;
        end else begin
            pll_enable <= pll_on;
            status <= '{mode: mode_q, pll_on: pll_on,
                        watchdog_on: wd_enabled, failover: failover_q};
        end
    end

endmodule
`default_nettype wire

// ===== testbench/ccss_props.sv
// Port checker for the CPU clock source select
`timescale 1ns/100ps
`default_nettype none
module ccss_props
    import ccss_pkg::*;
(
    input wire logic clock,
    input wire logic srst,
    input wire logic clock_input_pin,
    input wire logic system_config_wr,
    input wire logic [CFG_W-1:0] system_config_data,
    input wire logic clock_fail_irq_clear,
    input wire logic cpu_clock,
    input wire logic cpu_half_cycle,
    input wire logic clock_fail_irq,
    input wire logic pll_enable,
    input wire ccss_status_t status
);
    default clocking @(posedge clock); endclocking
    default disable iff (srst);
    logic pin_q;
    logic [7:0] idle_q;
    wire logic bypass = status.mode == STRAP_DIRECT
        || status.mode == STRAP_DIV2;
    // Cycles since the raw input last moved, saturating
    always_ff @(posedge clock) begin
        pin_q <= clock_input_pin;
        idle_q <= (srst || pin_q != clock_input_pin) ? 8'h00
            : idle_q + 8'(idle_q != 8'hff);
    end
    AST_HALF_EDGE: assert property ($changed(cpu_clock) |-> ##[0:1]
        cpu_half_cycle) else $error("edge without half-cycle pulse");
    AST_RESET_STATE: assert property (disable iff (1'b0) srst ##1 srst
        |-> !clock_fail_irq && pll_enable && !status.failover)
        else $error("wrong state in reset");
    AST_MODE_HOLD: assert property (!$past(srst) && !$past(srst, 2)
        && !$past(srst, 3) |-> $stable(status.mode))
        else $error("mode moved after reset");
    AST_IRQ_STICKY: assert property (clock_fail_irq
        && !clock_fail_irq_clear |=> clock_fail_irq)
        else $error("irq dropped without clear");
    AST_FAILOVER_HOLD: assert property (status.failover |=>
        status.failover) else $error("failover undone without reset");
    AST_PLL_OFF: assert property (system_config_wr && bypass
        && system_config_data[WD_DISABLE_BIT] |-> ##[1:2] !pll_enable)
        else $error("pll not switched off");
    AST_WD_EARLY: assert property ($rose(status.failover)
        |-> idle_q >= 8'h58) else $error("watchdog fired early");
    AST_WD_LATE: assert property (bypass && status.watchdog_on
        && idle_q == 8'ha0 |-> status.failover)
        else $error("watchdog fired late");
    AST_DIRECT_FOLLOW: assert property (status.mode == STRAP_DIRECT
        && !status.failover && !clock_fail_irq && !$past(srst, 3)
        |-> cpu_clock == $past(clock_input_pin, 3))
        else $error("direct clock not following input");
    cover property ($rose(status.failover));
    cover property (status.mode == STRAP_X5 && cpu_half_cycle);
    cover property (!pll_enable);
endmodule
bind ccss_top ccss_props props_u (.clock(clock), .srst(srst),
    .clock_input_pin(clock_input_pin), .system_config_wr(system_config_wr),
    .system_config_data(system_config_data),
    .clock_fail_irq_clear(clock_fail_irq_clear), .cpu_clock(cpu_clock),
    .cpu_half_cycle(cpu_half_cycle), .clock_fail_irq(clock_fail_irq),
    .pll_enable(pll_enable), .status(status));
`default_nettype wire

// ===== testbench/ccss_osc.sv
// Behavioural external oscillator with uneven duty cycle
`timescale 1ns/100ps
`default_nettype none
module ccss_osc #(
    parameter realtime HI_NS = 121.3,
    parameter realtime LO_NS = 198.7
) (
    input wire logic run,
    output logic osc
);
    // A dead crystal stalls at its last level
    initial begin
        osc = 1'b0;
        forever begin
            #(osc ? HI_NS : LO_NS);
            if (run) osc = !osc;
        end
    end
endmodule
`default_nettype wire

// ===== testbench/ccss_top_tb.sv
// Self-checking bench for the CPU clock source select
`timescale 1ns/100ps
`default_nettype none
module ccss_top_tb
    import ccss_pkg::*;
;
    // Half-cycles per 320 ns input period, indexed by strap code
    localparam logic [3:0] HALVES[8] = '{4'h5, 4'h1, 4'h3, 4'h2,
        4'ha, 4'h4, 4'h6, 4'h8};
    // Input period in system clock cycles: 320 ns at 8 ns
    localparam int XTAL_CYC = 40;
    logic clock = 1'b0;
    logic srst = 1'b1;
    logic run = 1'b1;
    logic osc;
    logic [STRAP_W-1:0] straps = STRAP_DEFAULT;
    logic cfg_wr = 1'b0;
    logic [CFG_W-1:0] cfg = CFG_RESET;
    logic clr = 1'b0;
    logic cpu_clk, half, irq, pll_en;
    ccss_status_t st;
    int err_total = 0;
    int checks_done = 0;
    initial forever #4 clock = ~clock;
    ccss_osc osc_u (.run(run), .osc(osc));
    ccss_top dut_u (.clock(clock), .srst(srst), .clock_input_pin(osc),
        .clock_strap_pins(straps), .system_config_wr(cfg_wr),
        .system_config_data(cfg), .clock_fail_irq_clear(clr),
        .cpu_clock(cpu_clk), .cpu_half_cycle(half), .clock_fail_irq(irq),
        .pll_enable(pll_en), .status(st));
    task automatic check(input string what, input logic [15:0] seen,
        input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            err_total++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wrap_up();
        if (err_total == 0 && checks_done > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task automatic do_reset(input logic [STRAP_W-1:0] s);
        @(negedge clock);
        straps = s;
        srst = 1'b1;
        repeat (4) @(negedge clock);
        srst = 1'b0;
        repeat (3) @(negedge clock);
        // Later strap activity must not matter
        straps = ~s;
        repeat (3) @(negedge clock);
    endtask
    task automatic cfg_write(input logic dis);
        cfg[WD_DISABLE_BIT] = dis;
        cfg_wr = 1'b1;
        @(negedge clock);
        cfg_wr = 1'b0;
        repeat (2) @(negedge clock);
    endtask
    task automatic count_halves(input int cycles, output int n);
        n = 0;
        repeat (cycles) begin
            @(negedge clock);
            n += half;
        end
    endtask
    // Cycles from the first cpu_clock edge seen to the edges-th after it
    task automatic span(input int edges, output int c);
        logic last;
        int e;
        int t0;
        last = cpu_clk;
        e = 0;
        t0 = 0;
        c = 0;
        for (int i = 0; i < 400 && e <= edges; i++) begin
            @(negedge clock);
            if (cpu_clk !== last) begin
                if (e == 0) begin
                    t0 = i;
                end
                e++;
                c = i - t0;
            end
            last = cpu_clk;
        end
    endtask
    task automatic t_modes();
        int n;
        for (int s = 0; s < 8; s++) begin
            do_reset(3'(s));
            check("mode", 16'(st.mode), 16'(s));
            repeat (120) @(negedge clock);
            count_halves(160, n);
            // Phase of the window allows two pulses fewer or one more
            check("halves", 16'((n + 2) / 4), 16'(HALVES[s]));
            if (3'(s) == STRAP_DIRECT) begin
                span(2, n);
                check("two halves", 16'(n), 16'(XTAL_CYC));
            end else if (3'(s) == STRAP_DIV2) begin
                span(1, n);
                check("one half", 16'(n), 16'(XTAL_CYC));
            end
        end
    endtask
    task automatic t_pll();
        do_reset(STRAP_DIRECT);
        check("pll", 16'(pll_en), 16'h0001);
        check("wd on", 16'(st.watchdog_on), 16'h0001);
        cfg_write(1'b1);
        check("pll", 16'(pll_en), 16'h0000);
        check("pll_on", 16'(st.pll_on), 16'h0000);
        check("wd on", 16'(st.watchdog_on), 16'h0000);
        run = 1'b0;
        repeat (250) @(negedge clock);
        check("irq", 16'(irq), 16'h0000);
        run = 1'b1;
        cfg_write(1'b0);
        check("pll", 16'(pll_en), 16'h0001);
        do_reset(STRAP_X4);
        cfg_write(1'b1);
        check("pll", 16'(pll_en), 16'h0001);
    endtask
    task automatic t_fail(input logic [STRAP_W-1:0] s);
        int n;
        do_reset(s);
        run = 1'b0;
        // Last input edge may precede the stop by a whole low phase
        repeat (60) @(negedge clock);
        check("irq", 16'(irq), 16'h0000);
        for (int i = 0; i < 60 && irq !== 1'b1; i++) @(negedge clock);
        if (irq !== 1'b1) begin
            err_total++;
            wrap_up();
        end
        // Long stall so the idle count of the late-watchdog check is reached
        count_halves(100, n);
        check("runs", 16'(n > 0), 16'h0001);
        run = 1'b1;
        repeat (100) @(negedge clock);
        check("failover", 16'(st.failover), 16'h0001);
        check("irq", 16'(irq), 16'h0001);
        clr = 1'b1;
        @(negedge clock);
        clr = 1'b0;
        @(negedge clock);
        check("irq", 16'(irq), 16'h0000);
        do_reset(s);
        check("failover", 16'(st.failover), 16'h0000);
    endtask
    initial begin
        t_modes();
        t_pll();
        t_fail(STRAP_DIRECT);
        t_fail(STRAP_DIV2);
        wrap_up();
    end
endmodule
`default_nettype wire
